// [core/tmm_consts.svh]
// tmm_consts.svh: offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the core files of the mode control.
// Operation
// - Shifter runs only while serial enable set
// - Shift clock idles at the polarity bit
// - Reserved mode bit five reads zero
// - Preset bit sets or clears toggle flip-flop
// - Preset ignored while timer enabled
// - Mode one drives no modulator pins
// - Toggle output on pin one or two
// - PWM output routing and fixed top choice
// - Mode five toggles output on enable
// - Serial data on pin one or two
// - Manchester: one rises, zero falls mid-bit
// - PWM code: high then low, two-thirds split
// - Load shifter from buffer, MSB first
// - Serial transmit and three-wire pin routing
// - Capture toggle routing, sensor mode drives none
// - Transmit empty flag set after reset
// - Serial disable clears receive flag
// - Top select picks fixed counter top
`ifndef TMM_CONSTS_SVH
`define TMM_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TMM_ADR_MODE_B 8'h00
`define TMM_ADR_MODE_A 8'h04
`define TMM_ADR_CTRL 8'h08
`define TMM_ADR_TXD 8'h0c
`define TMM_ADR_STAT 8'h10
`define TMM_ADR_RXD 8'h14

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define TMM_B_SSIE 7
`define TMM_B_CPOL 6
`define TMM_B_RSV 5
`define TMM_B_TOP 4
`define TMM_MODE_B_WMASK 8'hdf
`define TMM_MODE_B_RST 8'h00
`define TMM_MODE_A_RST 8'h00
`define TMM_A_TP_HI 7
`define TMM_A_TP_LO 6
`define TMM_C_TEN 0
`define TMM_C_CODE_HI 2
`define TMM_C_CODE_LO 1

// ---------------------------------------------------------------
// Fixed counter tops
// ---------------------------------------------------------------
`define TMM_TOP_OFF 10'h000
`define TMM_TOP_8 10'h0ff
`define TMM_TOP_9 10'h1ff
`define TMM_TOP_10 10'h3ff

// ---------------------------------------------------------------
// Line coding timing, in timer clock edges per bit
// ---------------------------------------------------------------
`define TMM_BIT_EDGES 3'd6
`define TMM_PH_LAST 3'd5
`define TMM_PH_MID 3'd3
`define TMM_PH_TWO_THIRD 3'd4
`define TMM_PH_ONE_THIRD 3'd2
`define TMM_BITS_LAST 3'd7

`endif

// [core/tmm_pkg.sv]
// tmm_pkg.sv: types shared by the timer mode control files
// Assumes tmm_consts.svh holds all numeric constants.
package tmm_pkg;

   // ---------------------------------------------------------------
   // Mode field encodings
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      MD_TIMER = 4'h0, MD_TOG1 = 4'h1, MD_TOG2 = 4'h2, MD_PWM1 = 4'h3,
      MD_PWM2 = 4'h4, MD_MOD1 = 4'h5, MD_MOD2 = 4'h6, MD_TX1 = 4'h7,
      MD_TX2 = 4'h8, MD_SPI = 4'h9, MD_CAP2 = 4'ha, MD_CAP1 = 4'hb,
      MD_SENSE = 4'hc, MD_RSV1 = 4'hd, MD_RSV2 = 4'he, MD_RSV3 = 4'hf
   } tmm_mode_t;

   // Line coding select
   typedef enum logic [1:0] {
      CD_NRZ = 2'h0, CD_MAN = 2'h1, CD_PWM = 2'h2, CD_RSV = 2'h3
   } tmm_code_t;

   // Shifter states, one-hot
   typedef enum logic [1:0] {
      SH_IDLE = 2'b01, SH_RUN = 2'b10
   } tmm_sh_state_t;

   // Three modulator pins, value and drive enable
   typedef struct packed {
      logic a_o;
      logic a_oe;
      logic b_o;
      logic b_oe;
      logic c_o;
      logic c_oe;
   } tmm_pins_t;

endpackage

// [core/tmm_line_coder.sv]
// tmm_line_coder.sv: turns one data bit and its phase into a line level
// Assumes phase counts timer clock edges within a bit, 0 to 5.
`timescale 1ns/10ps
`include "tmm_consts.svh"

module tmm_line_coder
   import tmm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bit and phase
   input wire tmm_code_t code_i,
   input wire logic bit_i,
   input wire logic [2:0] phase_i,
   // Coded level
   output logic level_o
);

   logic level_ff;
   logic nxt_level;

   // Level for the current phase
   always_comb begin
      case (code_i)
         CD_MAN: nxt_level = (phase_i < `TMM_PH_MID) ? ~bit_i : bit_i;
         CD_PWM: nxt_level = bit_i ? (phase_i < `TMM_PH_TWO_THIRD)
                                   : (phase_i < `TMM_PH_ONE_THIRD);
         default: nxt_level = bit_i;
      endcase
   end

   // Registered level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
      end
   end

   assign level_o = level_ff;

   chk_man_mid_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      (code_i == CD_MAN && phase_i >= `TMM_PH_MID) |=> level_o == $past(bit_i))
      else $error("Manchester second half does not carry the bit");

   chk_pwm_split: assert property (@(posedge clk_i) disable iff (rst_i)
      (code_i == CD_PWM && bit_i && phase_i == `TMM_PH_LAST) |=> !level_o)
      else $error("PWM code not low in last third");

endmodule

// [core/tmm_shifter.sv]
// tmm_shifter.sv: 8-bit serial shifter, MSB first, with receive side
// Assumes advance and sample pulses come from one clock domain.
`timescale 1ns/10ps
`include "tmm_consts.svh"

module tmm_shifter
   import tmm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic en_i,
   input wire logic load_i,
   input wire logic [7:0] data_i,
   input wire logic adv_i,
   input wire logic sample_i,
   input wire logic sdi_i,
   // Status and data
   output logic sdo_o,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] rx_o
);

   tmm_sh_state_t st_ff, nxt_st;
   logic [7:0] shreg_ff, nxt_shreg;
   logic [7:0] rx_ff, nxt_rx;
   logic [2:0] cnt_ff, nxt_cnt;
   logic done_ff, nxt_done;

   // Next state of the shifter
   always_comb begin
      nxt_st = st_ff;
      nxt_shreg = shreg_ff;
      nxt_rx = rx_ff;
      nxt_cnt = cnt_ff;
      nxt_done = 1'b0;
      case (st_ff)
         SH_IDLE: begin
            if (en_i && load_i) begin
               nxt_shreg = data_i;
               nxt_cnt = 3'd0;
               nxt_st = SH_RUN;
            end
         end
         SH_RUN: begin
            if (!en_i) begin
               nxt_st = SH_IDLE;
               nxt_shreg = 8'h00;
            end else begin
               if (sample_i) begin
                  nxt_rx = {rx_ff[6:0], sdi_i};
               end
               if (adv_i) begin
                  nxt_shreg = {shreg_ff[6:0], 1'b0};
                  nxt_cnt = cnt_ff + 3'd1;
                  if (cnt_ff == `TMM_BITS_LAST) begin
                     nxt_st = SH_IDLE;
                     nxt_done = 1'b1;
                  end
               end
            end
         end
         default: nxt_st = SH_IDLE;
      endcase
   end

   // Shifter registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= SH_IDLE;
         shreg_ff <= 8'h00;
         rx_ff <= 8'h00;
         cnt_ff <= 3'd0;
         done_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         shreg_ff <= nxt_shreg;
         rx_ff <= nxt_rx;
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign sdo_o = shreg_ff[7];
   assign busy_o = (st_ff == SH_RUN);
   assign done_o = done_ff;
   assign rx_o = rx_ff;

   chk_msb_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == SH_IDLE && en_i && load_i) |=> busy_o && sdo_o == $past(data_i[7]))
      else $error("Loaded word does not start with its MSB");

   chk_disable_stops: assert property (@(posedge clk_i) disable iff (rst_i)
      !en_i |=> !busy_o)
      else $error("Shifter runs with serial enable low");

endmodule

// [core/tmm_mode_ctrl.sv]
// tmm_mode_ctrl.sv: timer mode control with serial shifter and pin routing
// Assumes a classic Wishbone master on clk_i and an asynchronous timer
// output clock that paces the shifter.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "tmm_consts.svh"

module tmm_mode_ctrl
   import tmm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Counter core
   input wire logic toggle_event_i,
   input wire logic timer_clk_i,
   output logic timer_enable_o,
   output logic serial_enable_o,
   output logic toggle_o,
   output logic [9:0] top_value_o,
   // Modulator pins
   input wire logic [2:0] pin_i,
   output tmm_pins_t pins_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Pin routing for each mode
   function automatic tmm_pins_t route(tmm_mode_t m, logic tog, logic sdo,
                                       logic sck);
      tmm_pins_t p;
      p = '0;
      case (m)
         MD_TOG1, MD_PWM1, MD_CAP1: begin
            p.a_oe = 1'b1;
            p.a_o = tog;
         end
         MD_TOG2, MD_PWM2, MD_CAP2: begin
            p.b_oe = 1'b1;
            p.b_o = tog;
         end
         MD_MOD1: begin
            p.a_oe = 1'b1;
            p.a_o = sdo;
         end
         MD_MOD2: begin
            p.b_oe = 1'b1;
            p.b_o = sdo;
         end
         MD_TX1, MD_SPI: begin
            p.a_oe = 1'b1;
            p.a_o = sdo;
            p.b_oe = 1'b1;
            p.b_o = sck;
         end
         MD_TX2: begin
            p.a_oe = 1'b1;
            p.a_o = sck;
            p.b_oe = 1'b1;
            p.b_o = sdo;
         end
         default: p = '0;
      endcase
      return p;
   endfunction

   // ---------------------------------------------------------------
   // Register and bus state
   // ---------------------------------------------------------------
   logic [7:0] mode_b_ff, nxt_mode_b;
   logic [7:0] mode_a_ff, nxt_mode_a;
   logic [2:0] ctrl_ff, nxt_ctrl;
   logic [7:0] txd_ff, nxt_txd;
   logic tx_empty_ff, nxt_tx_empty;
   logic [7:0] rxd_ff, nxt_rxd;
   logic rx_flag_ff, nxt_rx_flag;
   logic toggle_ff, nxt_toggle;
   logic ten_d_ff, nxt_ten_d;
   logic ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;

   // Link side state
   logic tclk_s1_ff, tclk_s2_ff, tclk_s3_ff;
   logic sdi_s1_ff, sdi_s2_ff;
   logic [2:0] ph_ff, nxt_ph;
   tmm_pins_t pins_ff, nxt_pins;

   // Decoded control
   tmm_mode_t mode;
   tmm_code_t code;
   logic ssie, cpol, ten;
   logic req, wr_go, rd_go, rd_take;
   logic wr_mode_b, wr_txd, rd_rxd;
   logic serial_mode, coded, rise_p, fall_p;
   logic start, adv, sample, busy, done, sdo_raw, sdo_line, sck;
   logic [7:0] rx_word;
   logic [7:0] rdata;

   assign mode = tmm_mode_t'(mode_b_ff[3:0]);
   assign code = tmm_code_t'(ctrl_ff[`TMM_C_CODE_HI:`TMM_C_CODE_LO]);
   assign ssie = mode_b_ff[`TMM_B_SSIE];
   assign cpol = mode_b_ff[`TMM_B_CPOL];
   assign ten = ctrl_ff[`TMM_C_TEN];

   // Bus handshake terms, writes land on the acknowledged edge
   assign req = wb_cyc_i && wb_stb_i;
   assign rd_take = req && !ack_ff;
   assign wr_go = req && ack_ff && wb_we_i && wb_sel_i[0];
   assign rd_go = req && ack_ff && !wb_we_i;
   assign wr_mode_b = wr_go && (wb_adr_i == `TMM_ADR_MODE_B);
   assign wr_txd = wr_go && (wb_adr_i == `TMM_ADR_TXD);
   assign rd_rxd = rd_go && (wb_adr_i == `TMM_ADR_RXD);

   // ---------------------------------------------------------------
   // Read mux, unmapped reads return zero
   // ---------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      if (wb_adr_i == `TMM_ADR_MODE_B) begin
         rdata = mode_b_ff & `TMM_MODE_B_WMASK;
      end else if (wb_adr_i == `TMM_ADR_MODE_A) begin
         rdata = mode_a_ff;
      end else if (wb_adr_i == `TMM_ADR_CTRL) begin
         rdata = {5'h00, ctrl_ff};
      end else if (wb_adr_i == `TMM_ADR_TXD) begin
         rdata = txd_ff;
      end else if (wb_adr_i == `TMM_ADR_STAT) begin
         rdata = {4'h0, toggle_ff, busy, rx_flag_ff, tx_empty_ff};
      end else if (wb_adr_i == `TMM_ADR_RXD) begin
         rdata = rxd_ff;
      end
   end

   // ---------------------------------------------------------------
   // Register file, flags and toggle flip-flop
   // ---------------------------------------------------------------
   always_comb begin
      nxt_mode_b = mode_b_ff;
      nxt_mode_a = mode_a_ff;
      nxt_ctrl = ctrl_ff;
      nxt_txd = txd_ff;
      nxt_tx_empty = tx_empty_ff;
      nxt_rxd = rxd_ff;
      nxt_rx_flag = rx_flag_ff;
      nxt_toggle = toggle_ff;
      nxt_ten_d = ten;
      nxt_ack = rd_take;
      nxt_dat = rd_take ? {24'h000000, rdata} : dat_ff;
      if (wr_mode_b) begin
         nxt_mode_b = wb_dat_i[7:0] & `TMM_MODE_B_WMASK;
      end
      if (wr_go && wb_adr_i == `TMM_ADR_MODE_A) begin
         nxt_mode_a = wb_dat_i[7:0];
      end
      if (wr_go && wb_adr_i == `TMM_ADR_CTRL) begin
         nxt_ctrl = wb_dat_i[2:0];
      end
      // Buffer empties when the shifter takes it, fills on write
      if (wr_txd) begin
         nxt_txd = wb_dat_i[7:0];
         nxt_tx_empty = 1'b0;
      end else if (start) begin
         nxt_tx_empty = 1'b1;
      end
      // Received word; set beats the read clear, disable clears all
      if (done && mode == MD_SPI) begin
         nxt_rxd = rx_word;
         nxt_rx_flag = 1'b1;
      end else if (rd_rxd) begin
         nxt_rx_flag = 1'b0;
      end
      if (!ssie) begin
         nxt_rx_flag = 1'b0;
         nxt_rxd = 8'h00;
      end
      // Preset only while stopped, toggling only while running
      if (!ten) begin
         if (wr_mode_b) begin
            nxt_toggle = wb_dat_i[`TMM_B_TOP];
         end
      end else if (mode == MD_PWM2 && !ten_d_ff) begin
         nxt_toggle = ~toggle_ff;
      end else if (toggle_event_i && mode != MD_TIMER) begin
         nxt_toggle = ~toggle_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_b_ff <= `TMM_MODE_B_RST;
         mode_a_ff <= `TMM_MODE_A_RST;
         ctrl_ff <= 3'h0;
         txd_ff <= 8'h00;
         tx_empty_ff <= 1'b1;
         rxd_ff <= 8'h00;
         rx_flag_ff <= 1'b0;
         toggle_ff <= 1'b0;
         ten_d_ff <= 1'b0;
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else begin
         mode_b_ff <= nxt_mode_b;
         mode_a_ff <= nxt_mode_a;
         ctrl_ff <= nxt_ctrl;
         txd_ff <= nxt_txd;
         tx_empty_ff <= nxt_tx_empty;
         rxd_ff <= nxt_rxd;
         rx_flag_ff <= nxt_rx_flag;
         toggle_ff <= nxt_toggle;
         ten_d_ff <= nxt_ten_d;
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   // ---------------------------------------------------------------
   // Timer clock and serial input synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tclk_s1_ff <= 1'b0;
         tclk_s2_ff <= 1'b0;
         tclk_s3_ff <= 1'b0;
         sdi_s1_ff <= 1'b0;
         sdi_s2_ff <= 1'b0;
      end else begin
         tclk_s1_ff <= timer_clk_i;
         tclk_s2_ff <= tclk_s1_ff;
         tclk_s3_ff <= tclk_s2_ff;
         sdi_s1_ff <= pin_i[2];
         sdi_s2_ff <= sdi_s1_ff;
      end
   end

   assign rise_p = tclk_s2_ff && !tclk_s3_ff;
   assign fall_p = !tclk_s2_ff && tclk_s3_ff;

   // ---------------------------------------------------------------
   // Shifter pacing: coded modes use six edges a bit
   // ---------------------------------------------------------------
   assign serial_mode = (mode >= MD_MOD1) && (mode <= MD_SPI);
   assign coded = (mode == MD_MOD1 || mode == MD_MOD2) && code != CD_NRZ;
   // Load just after a timer clock fall, so data settles before the first rise
   assign start = ssie && serial_mode && !busy && !tx_empty_ff && fall_p;
   assign adv = coded ? ((rise_p || fall_p) && ph_ff == `TMM_PH_LAST) : fall_p;
   assign sample = rise_p && mode == MD_SPI;
   // Shift clock rests at the polarity level between words
   assign sck = cpol ^ (busy && tclk_s2_ff);

   always_comb begin
      nxt_ph = ph_ff;
      if (!busy || !coded) begin
         nxt_ph = 3'd0;
      end else if (rise_p || fall_p) begin
         nxt_ph = (ph_ff == `TMM_PH_LAST) ? 3'd0 : ph_ff + 3'd1;
      end
      nxt_pins = route(mode, toggle_ff, sdo_line, sck);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_ff <= 3'd0;
         pins_ff <= '0;
      end else begin
         ph_ff <= nxt_ph;
         pins_ff <= nxt_pins;
      end
   end

   // ---------------------------------------------------------------
   // Shifter and line coder
   // ---------------------------------------------------------------
   tmm_shifter u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ssie),
      .load_i(start),
      .data_i(txd_ff),
      .adv_i(adv),
      .sample_i(sample),
      .sdi_i(sdi_s2_ff),
      .sdo_o(sdo_raw),
      .busy_o(busy),
      .done_o(done),
      .rx_o(rx_word)
   );

   logic coded_lvl;

   tmm_line_coder u_coder (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .code_i(coded ? code : CD_NRZ),
      .bit_i(sdo_raw),
      .phase_i(ph_ff),
      .level_o(coded_lvl)
   );

   assign sdo_line = !busy ? 1'b0 : (coded ? coded_lvl : sdo_raw);

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      case (mode_a_ff[`TMM_A_TP_HI:`TMM_A_TP_LO])
         2'd1: top_value_o = `TMM_TOP_8;
         2'd2: top_value_o = `TMM_TOP_9;
         2'd3: top_value_o = `TMM_TOP_10;
         default: top_value_o = `TMM_TOP_OFF;
      endcase
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign timer_enable_o = ten;
   assign serial_enable_o = ssie;
   assign toggle_o = toggle_ff;
   assign pins_o = pins_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_preset_wr;
      wr_mode_b && !ten;
   endsequence

   sequence s_enable_rise;
      ten && !ten_d_ff && mode == MD_PWM2;
   endsequence

   chk_rsv_reads_zero: assert property (
      (rd_take && wb_adr_i == `TMM_ADR_MODE_B) |=> !wb_dat_o[`TMM_B_RSV])
      else $error("Reserved mode bit read as one");

   chk_preset_loads: assert property (
      s_preset_wr |=> toggle_o == $past(wb_dat_i[`TMM_B_TOP]))
      else $error("Preset write did not reach toggle flip-flop");

   chk_preset_blocked: assert property (
      (ten && ten_d_ff && !toggle_event_i) |=> $stable(toggle_o))
      else $error("Toggle moved while enabled without an event");

   chk_enable_kick: assert property (
      s_enable_rise |=> toggle_o != $past(toggle_o))
      else $error("Mode five enable did not toggle output");

   chk_timer_no_pins: assert property (
      (mode == MD_TIMER) [*2] |-> !pins_o.a_oe && !pins_o.b_oe && !pins_o.c_oe)
      else $error("Interval timer mode drives a pin");

   chk_tog_route: assert property (
      (mode == MD_TOG1) |=> pins_o.a_oe && pins_o.a_o == $past(toggle_o))
      else $error("Toggle output missing on pin one");

   chk_sck_idle: assert property (
      (mode == MD_TX1 && !busy) |=> pins_o.b_o == $past(cpol))
      else $error("Shift clock not at idle polarity");

   chk_rx_cleared: assert property (
      !ssie |=> !rx_flag_ff)
      else $error("Receive flag survives serial disable");

   chk_top_select: assert property (
      (mode_a_ff[`TMM_A_TP_HI:`TMM_A_TP_LO] == 2'd2) |-> top_value_o == `TMM_TOP_9)
      else $error("Top select two gives wrong top");

   chk_ack_timing: assert property (
      (req && !ack_ff) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Bus acknowledge not a single cycle after request");

endmodule

// [sim/tmm_peer.sv]
// tmm_peer.sv: behavioural serial peripheral on the three-wire link
// Assumes shift clock, data out and data in as plain levels.
`timescale 1ns/10ps

module tmm_peer (
   // Control
   input wire logic rst_i,
   input wire logic [7:0] tx_i,
   // Link
   input wire logic sclk_i,
   input wire logic sdo_i,
   output logic sdi_o,
   output logic [7:0] rx_o
);
   int tc;

   // Sample data on the rising shift clock edge
   always @(posedge sclk_i) begin
      rx_o <= {rx_o[6:0], sdo_i};
   end

   // Change own data on the falling edge
   always @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         tc <= 0;
      end else begin
         tc <= tc + 1;
      end
   end

   // Released after eight bits: shows the inverse of the last bit
   assign sdi_o = (tc < 8) ? tx_i[7 - tc] : ~tx_i[0];
endmodule

// [sim/timer_modulator_mode_control_tb.sv]
// Bench for the timer mode control: register bus, pin routing, shifter
// Assumes one design instance and the serial peer on the three-wire pins.
`timescale 1ns/10ps
`include "tmm_consts.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module timer_modulator_mode_control_tb import tmm_pkg::*;;
   typedef struct packed {logic [7:0] w; logic [7:0] r; logic [2:0] oe;} tmm_row_t;
   tmm_row_t rows [16] = '{'{8'h00, 8'h00, 3'h0}, '{8'h11, 8'h11, 3'h4},
      '{8'h02, 8'h02, 3'h2}, '{8'h23, 8'h03, 3'h4}, '{8'h04, 8'h04, 3'h2},
      '{8'h85, 8'h85, 3'h4}, '{8'h86, 8'h86, 3'h2}, '{8'h87, 8'h87, 3'h6},
      '{8'hc8, 8'hc8, 3'h6}, '{8'h89, 8'h89, 3'h6}, '{8'h0a, 8'h0a, 3'h2},
      '{8'h0b, 8'h0b, 3'h4}, '{8'h0c, 8'h0c, 3'h0}, '{8'h0d, 8'h0d, 3'h0},
      '{8'h0e, 8'h0e, 3'h0}, '{8'h0f, 8'h0f, 3'h0}};
   logic [9:0] tops [4] = '{10'h000, 10'h0ff, 10'h1ff, 10'h3ff};
   logic clk_i = 0, rst_i = 1, prst = 1, tclk = 0, cyc = 0, stb = 0, we = 0, te = 0;
   logic [7:0] adr = 0, q;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, wb_dat_o;
   logic wb_ack_o, timer_enable_o, serial_enable_o, toggle_o, sdi;
   logic [9:0] top_value_o;
   logic [7:0] peer_rx;
   tmm_pins_t pins_o;
   int err_count = 0, total_checks = 0;

   // Clocks: system and free-running timer clock
   initial forever #4 clk_i = ~clk_i;
   initial forever #62.5 tclk = ~tclk;

   tmm_mode_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .toggle_event_i(te), .timer_clk_i(tclk),
      .timer_enable_o(timer_enable_o), .serial_enable_o(serial_enable_o),
      .toggle_o(toggle_o), .top_value_o(top_value_o), .pin_i({sdi, 2'b01}),
      .pins_o(pins_o));

   tmm_peer peer (.rst_i(prst), .tx_i(8'h3c), .sclk_i(pins_o.b_o), .sdo_i(pins_o.a_o),
      .sdi_o(sdi), .rx_o(peer_rx));

   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic s);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= {3'h0, s};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o[7:0];
      cyc <= 0; stb <= 0; we <= 0;
      if (k >= 50) begin
         err_count++;
         summarize();
      end
   endtask

   // Poll status until busy, receive and empty flags read as v
   task automatic wait_stat(input logic [2:0] v);
      int m;
      m = 0;
      do begin
         wb(0, `TMM_ADR_STAT, 0, 1);
         m++;
      end while (q[2:0] !== v && m < 300);
      if (m >= 300) begin
         err_count++;
         summarize();
      end
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      wb(0, `TMM_ADR_MODE_B, 0, 1); `CHK(q, 8'h00)
      wb(0, `TMM_ADR_STAT, 0, 1); `CHK(q[1:0], 2'b01)
      wb(0, 8'h20, 0, 1); `CHK(q, 8'h00)
      wb(1, `TMM_ADR_MODE_A, 8'hff, 0); wb(0, `TMM_ADR_MODE_A, 0, 1); `CHK(q, 8'h00)
      // Mode table: readback, pin drive, preset
      foreach (rows[i]) begin
         wb(1, `TMM_ADR_MODE_B, rows[i].w, 1); wb(0, `TMM_ADR_MODE_B, 0, 1);
         `CHK(q, rows[i].r)
         repeat (3) @(negedge clk_i);
         `CHK({pins_o.a_oe, pins_o.b_oe, pins_o.c_oe}, rows[i].oe)
         `CHK(toggle_o, rows[i].w[4])
      end
      for (int i = 0; i < 4; i++) begin
         wb(1, `TMM_ADR_MODE_A, 8'(i << 6), 1); @(negedge clk_i);
         `CHK(top_value_o, tops[i])
      end
      for (int p = 0; p < 2; p++) begin
         wb(1, `TMM_ADR_MODE_B, {1'b1, p[0], 6'h08}, 1); repeat (3) @(negedge clk_i);
         `CHK(pins_o.a_o, p[0])
      end
      // Enable toggles in mode five, preset ignored, event toggles
      wb(1, `TMM_ADR_MODE_B, 8'h04, 1); wb(1, `TMM_ADR_CTRL, 8'h01, 1);
      repeat (3) @(negedge clk_i); `CHK(toggle_o, 1'b1)
      `CHK(timer_enable_o, 1'b1)
      wb(1, `TMM_ADR_MODE_B, 8'h04, 1); repeat (3) @(negedge clk_i);
      `CHK(toggle_o, 1'b1)
      @(posedge clk_i) te <= 1;
      @(posedge clk_i) te <= 0;
      repeat (2) @(negedge clk_i); `CHK(toggle_o, 1'b0)
      // Three-wire transfers, received word, then serial disable
      wb(1, `TMM_ADR_CTRL, 8'h00, 1); wb(1, `TMM_ADR_MODE_B, 8'h89, 1);
      @(negedge clk_i); `CHK(serial_enable_o, 1'b1)
      @(posedge clk_i) prst <= 0;
      wb(1, `TMM_ADR_TXD, 8'ha5, 1); wait_stat(3'b011);
      `CHK(peer_rx, 8'ha5)
      `CHK(q[1:0], 2'b11)
      wb(0, `TMM_ADR_RXD, 0, 1); `CHK(q, 8'h3c)
      wb(0, `TMM_ADR_STAT, 0, 1); `CHK(q[1], 1'b0)
      wb(1, `TMM_ADR_TXD, 8'h5a, 1); wait_stat(3'b011);
      `CHK(peer_rx, 8'h5a)
      wb(1, `TMM_ADR_MODE_B, 8'h09, 1); wb(0, `TMM_ADR_STAT, 0, 1);
      `CHK(q[1], 1'b0)
      `CHK(serial_enable_o, 1'b0)
      wb(0, `TMM_ADR_RXD, 0, 1); `CHK(q, 8'h00)
      // Coded modulator words, Manchester then PWM code
      wb(1, `TMM_ADR_MODE_B, 8'h85, 1);
      for (int c = 1; c < 3; c++) begin
         wb(1, `TMM_ADR_CTRL, 8'(c << 1), 1); wb(1, `TMM_ADR_TXD, 8'h96, 1);
         wait_stat(3'b001); `CHK(pins_o.a_o, 1'b0)
      end
      summarize();
   end
endmodule
